// >>> logic/fbc_core.sv
// execution core of the 4-bit controller: memory, alu, timer, ports
// Function
// - data memory is six rows of sixteen nibbles, row and column pointer
// - results go to the 4-bit accumulator; one carry flop records carry
// - one memory nibble is a flag word, bits set, cleared, tested
// - six memory nibbles are working registers, addressed without the pointer
// - timer is 6-bit polynomial prescaler driving 6-bit binary counter
// - timer load clears timeout flag, loads counter; test op skips
// - timer counts after load ends; six bits select 64 intervals
// - nine ports A to I, 35 lines, port I three bits
// - A,B inputs; C,D bidirectional; E to I outputs
// - generic port ops use port code in pointer column bits
// - port bit set, clear, test-skip, nibble in/out, 8-bit C,D out
// - memory increment adds one, skips when result wraps to zero
// - interrupt test skips on request flag and clears it
// - rotate right through carry: bit 0 to carry, carry to bit 3
// - add with carry into accumulator and carry, skip variant on carry
// - swap with memory then step column, skip on wrap to 0 or F
// - load memory to accumulator, row xor two-bit immediate
// - decimal fix adds 6 after addition, 10 after subtraction
// - flag test skips on selected bit one, or zero for twin
// - pc is 3-bit field above 8-bit up-counter
// - three-deep return stack saves pc on call and interrupt
`timescale 1ns/1ps
`include "fbc_defs.svh"
module fbc_core (
  input logic clk,
  input logic rst_n,
  output logic [10:0] rom_addr,
  input logic [7:0] rom_data,
  input logic int_req,
  input logic [3:0] port_a,
  input logic [3:0] port_b,
  input logic [3:0] port_c_in,
  output logic [3:0] port_c_out,
  output logic port_c_oe_n,
  input logic [3:0] port_d_in,
  output logic [3:0] port_d_out,
  output logic port_d_oe_n,
  output logic [3:0] port_e,
  output logic [3:0] port_f,
  output logic [3:0] port_g,
  output logic [3:0] port_h,
  output logic [2:0] port_i,
  output logic timeout_flag,
  output logic interrupt_allow_flag
);
  import fbc_pkg::*;

  // ==========================================
  // state
  fbc_state_type st_q, st_d;
  logic [10:0] pc_q, pc_d, push_val;
  logic [10:0] stk_q [0:2];
  logic [7:0] op_q;
  logic drop_q, drop_d, skip_q, skip_d;
  logic [3:0] acc_q, acc_d;
  logic c_q, c_d;
  logic [2:0] row_q, row_d;
  logic [3:0] col_q, col_d;
  logic [3:0] ram_q [0:`FBC_RAM_WORDS-1];
  logic ram_we;
  logic [6:0] ram_wa;
  logic [3:0] ram_wd, mem_rd, flag_word;
  logic [3:0] pout_q [0:8];
  logic [1:0] cd_drv_q;
  logic pwe, ocd_we;
  logic [3:0] pwd;
  logic [5:0] pre_q, tm_cnt_q;
  logic tm_flag_q, tm_load, tm_set;
  logic int_flag_q, int_req_q, int_rise, int_clr, allow_q, allow_d;
  logic push, pop, run, take_int, flag_bit;
  logic [4:0] add_sum;

  // ==========================================
  // helpers
  function automatic logic two_byte(input logic [7:0] op);
    casez (op)
      `FBC_TIMER_LOAD_OP, `FBC_DUAL_PORT_IMMEDIATE_OUT_OP,
      `FBC_LOAD_POINTER_OP, `FBC_JUMP_OP, `FBC_CALL_OP: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] bit_mask(input logic [1:0] b);
    return 4'h1 << b;
  endfunction

  // inputs read the pins, outputs read back their latch
  function automatic logic [3:0] port_read(input logic [3:0] code);
    case (code)
      `FBC_PORT_A: return port_a;
      `FBC_PORT_B: return port_b;
      `FBC_PORT_C: return port_c_in;
      `FBC_PORT_D: return port_d_in;
      default: return (code <= `FBC_PORT_I) ? pout_q[code] : 4'h0;
    endcase
  endfunction

  // rows 6 and 7 do not exist: read zero, writes dropped
  assign mem_rd = (row_q < `FBC_RAM_ROWS) ? ram_q[{row_q, col_q}] : 4'h0;
  assign flag_word = ram_q[`FBC_FLAG_ADDR];
  assign flag_bit = flag_word[rom_data[1:0]];
  assign add_sum = {1'b0, acc_q} + {1'b0, mem_rd} + {4'h0, c_q};
  assign int_rise = int_req & ~int_req_q;
  assign take_int = (st_q == fbc_exec) && !skip_q && allow_q && int_flag_q;
  assign run = (st_q == fbc_exec) && !skip_q && !take_int;
  assign rom_addr = pc_q;

  // ==========================================
  // instruction decode
  always_comb begin
    st_d = fbc_exec;
    pc_d = {pc_q[10:8], pc_q[7:0] + 8'h01};
    push_val = pc_d;
    acc_d = acc_q;
    c_d = c_q;
    row_d = row_q;
    col_d = col_q;
    skip_d = 1'b0;
    drop_d = 1'b0;
    ram_we = 1'b0;
    ram_wa = {row_q, col_q};
    ram_wd = acc_q;
    pwe = 1'b0;
    pwd = acc_q;
    ocd_we = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    tm_load = 1'b0;
    int_clr = 1'b0;
    allow_d = allow_q;
    if (st_q == fbc_imm) begin
      if (!drop_q) begin
        casez (op_q)
          `FBC_TIMER_LOAD_OP: tm_load = 1'b1;
          `FBC_DUAL_PORT_IMMEDIATE_OUT_OP: ocd_we = 1'b1;
          `FBC_LOAD_POINTER_OP: begin
            row_d = rom_data[6:4];
            col_d = rom_data[3:0];
          end
          `FBC_JUMP_OP: pc_d = {op_q[2:0], rom_data};
          `FBC_CALL_OP: begin
            push = 1'b1;
            pc_d = {op_q[2:0], rom_data};
          end
          default: ;
        endcase
      end
    end else if (take_int) begin
      // the fetched byte is abandoned and re-run after return
      push = 1'b1;
      push_val = pc_q;
      pc_d = `FBC_INT_VEC;
      int_clr = 1'b1;
      allow_d = 1'b0;
    end else if (skip_q) begin
      // a skipped two-byte op takes its immediate byte with it
      if (two_byte(rom_data)) begin
        st_d = fbc_imm;
        drop_d = 1'b1;
      end
    end else begin
      if (two_byte(rom_data)) begin
        st_d = fbc_imm;
      end
      casez (rom_data)
        `FBC_ROTATE_RIGHT_OP: begin
          acc_d = {c_q, acc_q[3:1]};
          c_d = acc_q[0];
        end
        `FBC_MEMORY_INCREMENT_OP: begin
          ram_we = 1'b1;
          ram_wd = mem_rd + 4'h1;
          skip_d = (mem_rd == 4'hf);
        end
        `FBC_MEMORY_DECREMENT_OP: begin
          ram_we = 1'b1;
          ram_wd = mem_rd - 4'h1;
          skip_d = (mem_rd == 4'h0);
        end
        `FBC_ADD_CARRY_SKIP_OP, `FBC_ADD_CARRY_OP: begin
          acc_d = add_sum[3:0];
          c_d = add_sum[4];
          skip_d = add_sum[4] && (rom_data == `FBC_ADD_CARRY_SKIP_OP);
        end
        `FBC_DECIMAL_FIX_ADD_OP: acc_d = acc_q + 4'h6;
        `FBC_DECIMAL_FIX_SUB_OP: acc_d = acc_q + 4'ha;
        `FBC_SWAP_AND_STEP_UP_OP, `FBC_SWAP_AND_STEP_DOWN_OP: begin
          acc_d = mem_rd;
          ram_we = 1'b1;
          if (rom_data == `FBC_SWAP_AND_STEP_UP_OP) begin
            col_d = col_q + 4'h1;
            skip_d = (col_q == 4'hf);
          end else begin
            col_d = col_q - 4'h1;
            skip_d = (col_q == 4'h0);
          end
        end
        `FBC_LOAD_OP: acc_d = mem_rd;
        `FBC_STORE_OP: ram_we = 1'b1;
        `FBC_CLEAR_ACC_OP: acc_d = 4'h0;
        `FBC_TIMEOUT_TEST_OP: skip_d = tm_flag_q;
        `FBC_INTERRUPT_TEST_OP: begin
          skip_d = int_flag_q;
          int_clr = 1'b1;
        end
        `FBC_PORT_OUT_OP: pwe = 1'b1;
        `FBC_PORT_IN_OP: acc_d = port_read(col_q);
        `FBC_PORT_A_IN_OP: acc_d = port_a;
        `FBC_ALLOW_INT_OP: allow_d = 1'b1;
        `FBC_BLOCK_INT_OP: allow_d = 1'b0;
        `FBC_RETURN_OP: begin
          pc_d = stk_q[0];
          pop = 1'b1;
        end
        `FBC_ACC_TO_COL_OP: col_d = acc_q;
        `FBC_COL_TO_ACC_OP: acc_d = col_q;
        // working registers are addressed without the pointer; row and column swaps reload it
        `FBC_SWAP_ROW_X_OP, `FBC_SWAP_ROW_R_OP, `FBC_ROW_TO_X_OP: begin
          ram_wa = (rom_data == `FBC_SWAP_ROW_R_OP) ? `FBC_REG_R
                                                    : `FBC_REG_X;
          ram_we = 1'b1;
          ram_wd = {1'b0, row_q};
          if (rom_data != `FBC_ROW_TO_X_OP) begin
            row_d = ram_q[ram_wa][2:0];
          end
        end
        `FBC_SWAP_COL_Y_OP, `FBC_SWAP_COL_S_OP, `FBC_COL_TO_Y_OP: begin
          ram_wa = (rom_data == `FBC_SWAP_COL_S_OP) ? `FBC_REG_S
                                                    : `FBC_REG_Y;
          ram_we = 1'b1;
          ram_wd = col_q;
          if (rom_data != `FBC_COL_TO_Y_OP) begin
            col_d = ram_q[ram_wa];
          end
        end
        `FBC_SWAP_ACC_Z_OP, `FBC_SWAP_ACC_W_OP, `FBC_ACC_TO_Z_OP,
        `FBC_ACC_TO_W_OP: begin
          ram_wa = rom_data[0] ? `FBC_REG_W : `FBC_REG_Z;
          ram_we = 1'b1;
          if (!rom_data[1]) begin
            acc_d = ram_q[ram_wa];
          end
        end
        `FBC_LOAD_AND_MODIFY_OP: begin
          acc_d = mem_rd;
          row_d = row_q ^ {1'b0, rom_data[1:0]};
        end
        `FBC_FLAG_TRUE_TEST_OP: skip_d = flag_bit;
        `FBC_FLAG_FALSE_TEST_OP: skip_d = !flag_bit;
        `FBC_FLAG_SET_OP, `FBC_FLAG_CLEAR_OP: begin
          ram_wa = `FBC_FLAG_ADDR;
          ram_we = 1'b1;
          ram_wd = rom_data[6] ? (flag_word & ~bit_mask(rom_data[1:0]))
                               : (flag_word | bit_mask(rom_data[1:0]));
        end
        `FBC_PORT_BIT_SET_OP: begin
          pwe = 1'b1;
          pwd = port_read(col_q) | bit_mask(rom_data[1:0]);
        end
        `FBC_PORT_BIT_CLEAR_OP: begin
          pwe = 1'b1;
          pwd = port_read(col_q) & ~bit_mask(rom_data[1:0]);
        end
        `FBC_PORT_BIT_TEST_OP: begin
          skip_d = |(port_read(col_q) & bit_mask(rom_data[1:0]));
        end
        `FBC_LOAD_COL_OP: begin
          row_d = 3'h0;
          col_d = rom_data[3:0];
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // sequencer, pc and return stack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= fbc_exec;
      pc_q <= `FBC_RESET_PC;
      op_q <= 8'h00;
      drop_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
      op_q <= rom_data;
      drop_q <= drop_d;
      skip_q <= skip_d;
    end
  end

  // a fourth nested call pushes the oldest return address out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        stk_q[i] <= `FBC_RESET_PC;
      end
    end else if (push) begin
      stk_q[0] <= push_val;
      stk_q[1] <= stk_q[0];
      stk_q[2] <= stk_q[1];
    end else if (pop) begin
      stk_q[0] <= stk_q[1];
      stk_q[1] <= stk_q[2];
    end
  end

  // accumulator, carry and data pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 4'h0;
      c_q <= 1'b0;
      row_q <= 3'h0;
      col_q <= 4'h0;
    end else begin
      acc_q <= acc_d;
      c_q <= c_d;
      row_q <= row_d;
      col_q <= col_d;
    end
  end

  // data memory has no reset; software initialises it
  always_ff @(posedge clk) begin
    if (ram_we && (ram_wa[6:4] < `FBC_RAM_ROWS)) begin
      ram_q[ram_wa] <= ram_wd;
    end
  end

  // ==========================================
  // ports: C and D stay released until first written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 9; i++) begin
        pout_q[i] <= 4'h0;
      end
      cd_drv_q <= 2'b00;
    end else if (ocd_we) begin
      pout_q[`FBC_PORT_C] <= rom_data[3:0];
      pout_q[`FBC_PORT_D] <= rom_data[7:4];
      cd_drv_q <= 2'b11;
    end else if (pwe && (col_q >= `FBC_PORT_C) && (col_q <= `FBC_PORT_I)) begin
      pout_q[col_q] <= (col_q == `FBC_PORT_I) ? {1'b0, pwd[2:0]} : pwd;
      if (col_q == `FBC_PORT_C) begin
        cd_drv_q[0] <= 1'b1;
      end
      if (col_q == `FBC_PORT_D) begin
        cd_drv_q[1] <= 1'b1;
      end
    end else if (run && (rom_data == `FBC_PORT_E_OUT_OP)) begin
      pout_q[`FBC_PORT_E] <= acc_q;
    end
  end

  assign port_c_out = pout_q[`FBC_PORT_C];
  assign port_d_out = pout_q[`FBC_PORT_D];
  assign port_c_oe_n = ~cd_drv_q[0];
  assign port_d_oe_n = ~cd_drv_q[1];
  assign port_e = pout_q[`FBC_PORT_E];
  assign port_f = pout_q[`FBC_PORT_F];
  assign port_g = pout_q[`FBC_PORT_G];
  assign port_h = pout_q[`FBC_PORT_H];
  assign port_i = pout_q[`FBC_PORT_I][2:0];

  // ==========================================
  // interval timer: lfsr prescaler of period 63, then binary count
  assign tm_set = (pre_q == `FBC_PRE_TICK) && (tm_cnt_q == `FBC_TM_LAST);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= `FBC_PRE_SEED;
      tm_cnt_q <= 6'h00;
    end else if (tm_load) begin
      pre_q <= `FBC_PRE_SEED;
      tm_cnt_q <= rom_data[5:0];
    end else begin
      pre_q <= {pre_q[4:0], pre_q[5] ^ pre_q[4]};
      if (pre_q == `FBC_PRE_TICK) begin
        tm_cnt_q <= tm_cnt_q + 6'h01;
      end
    end
  end

  // a timeout in the load cycle still wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tm_flag_q <= 1'b0;
    end else if (tm_set) begin
      tm_flag_q <= 1'b1;
    end else if (tm_load) begin
      tm_flag_q <= 1'b0;
    end
  end
  assign timeout_flag = tm_flag_q;

  // interrupt request: rising edge sets, test or acknowledge clears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_req_q <= 1'b0;
      int_flag_q <= 1'b0;
      allow_q <= 1'b0;
    end else begin
      int_req_q <= int_req;
      allow_q <= allow_d;
      if (int_rise) begin
        int_flag_q <= 1'b1;
      end else if (int_clr) begin
        int_flag_q <= 1'b0;
      end
    end
  end
  assign interrupt_allow_flag = allow_q;

  // ==========================================
  // checks
  logic [3:0] prev_acc_q, prev_col_q;
  logic [7:0] prev_imm_q;
  logic prev_c_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_acc_q <= 4'h0;
      prev_col_q <= 4'h0;
      prev_imm_q <= 8'h00;
      prev_c_q <= 1'b0;
    end else begin
      prev_acc_q <= acc_q;
      prev_col_q <= col_q;
      prev_imm_q <= rom_data;
      prev_c_q <= c_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rar;
    run && rom_data == `FBC_ROTATE_RIGHT_OP |=>
      acc_q == {prev_c_q, prev_acc_q[3:1]} && c_q == prev_acc_q[0];
  endproperty
  a_rar: assert property (p_rar) else $error("rotate wrong");

  property p_daa;
    run && rom_data == `FBC_DECIMAL_FIX_ADD_OP |=> acc_q == prev_acc_q + 4'h6;
  endproperty
  a_daa: assert property (p_daa) else $error("fix add wrong");

  property p_das;
    run && rom_data == `FBC_DECIMAL_FIX_SUB_OP |=> acc_q == prev_acc_q + 4'ha;
  endproperty
  a_das: assert property (p_das) else $error("fix sub wrong");

  property p_ads;
    run && rom_data == `FBC_ADD_CARRY_SKIP_OP && add_sum[4] |=> skip_q && c_q;
  endproperty
  a_ads: assert property (p_ads) else $error("add skip lost");

  property p_inm;
    run && rom_data == `FBC_MEMORY_INCREMENT_OP |=>
      skip_q == ($past(mem_rd) == 4'hf);
  endproperty
  a_inm: assert property (p_inm) else $error("inc skip wrong");

  property p_xi;
    run && rom_data == `FBC_SWAP_AND_STEP_UP_OP |=>
      col_q == prev_col_q + 4'h1 && skip_q == (col_q == 4'h0);
  endproperty
  a_xi: assert property (p_xi) else $error("swap step wrong");

  property p_tit;
    run && rom_data == `FBC_INTERRUPT_TEST_OP && int_flag_q && !int_rise
      |=> !int_flag_q && skip_q;
  endproperty
  a_tit: assert property (p_tit) else $error("int test wrong");

  property p_stm;
    st_q == fbc_imm && !drop_q && op_q == `FBC_TIMER_LOAD_OP && !tm_set
      |=> tm_cnt_q == prev_imm_q[5:0] && !tm_flag_q;
  endproperty
  a_stm: assert property (p_stm) else $error("timer load wrong");

  property p_ocd;
    st_q == fbc_imm && !drop_q && op_q == `FBC_DUAL_PORT_IMMEDIATE_OUT_OP
      |=> port_c_out == prev_imm_q[3:0] && port_d_out == prev_imm_q[7:4]
          && !port_c_oe_n && !port_d_oe_n;
  endproperty
  a_ocd: assert property (p_ocd) else $error("dual out wrong");

  property p_fbt;
    run && (rom_data ==? `FBC_FLAG_TRUE_TEST_OP) |=> skip_q == $past(flag_bit);
  endproperty
  a_fbt: assert property (p_fbt) else $error("flag test wrong");

  c_ads_skip: cover property (run && rom_data == `FBC_ADD_CARRY_SKIP_OP
                              && add_sum[4]);
  c_int_take: cover property (take_int);
  c_timeout: cover property (tm_set);
endmodule // fbc_core

// >>> logic/fbc_defs.svh
// opcode map, memory layout and timer constants of the controller core
`ifndef FBC_DEFS_SVH
`define FBC_DEFS_SVH
// ==========================================
// single-byte opcodes
`define FBC_NOP_OP 8'h00
`define FBC_ROTATE_RIGHT_OP 8'h01
`define FBC_MEMORY_INCREMENT_OP 8'h02
`define FBC_MEMORY_DECREMENT_OP 8'h03
`define FBC_ADD_CARRY_SKIP_OP 8'h04
`define FBC_ADD_CARRY_OP 8'h05
`define FBC_DECIMAL_FIX_ADD_OP 8'h06
`define FBC_DECIMAL_FIX_SUB_OP 8'h07
`define FBC_SWAP_AND_STEP_UP_OP 8'h08
`define FBC_SWAP_AND_STEP_DOWN_OP 8'h09
`define FBC_LOAD_OP 8'h0a
`define FBC_STORE_OP 8'h0b
`define FBC_CLEAR_ACC_OP 8'h0c
`define FBC_TIMEOUT_TEST_OP 8'h0d
`define FBC_INTERRUPT_TEST_OP 8'h0e
`define FBC_PORT_OUT_OP 8'h0f
`define FBC_PORT_IN_OP 8'h10
`define FBC_PORT_E_OUT_OP 8'h11
`define FBC_PORT_A_IN_OP 8'h12
`define FBC_ALLOW_INT_OP 8'h13
`define FBC_BLOCK_INT_OP 8'h14
`define FBC_RETURN_OP 8'h15
`define FBC_ACC_TO_COL_OP 8'h16
`define FBC_COL_TO_ACC_OP 8'h17
`define FBC_SWAP_ROW_X_OP 8'h18
`define FBC_SWAP_COL_Y_OP 8'h19
`define FBC_ROW_TO_X_OP 8'h1a
`define FBC_COL_TO_Y_OP 8'h1b
`define FBC_SWAP_ACC_Z_OP 8'h1c
`define FBC_SWAP_ACC_W_OP 8'h1d
`define FBC_ACC_TO_Z_OP 8'h1e
`define FBC_ACC_TO_W_OP 8'h1f
`define FBC_SWAP_ROW_R_OP 8'h20
`define FBC_SWAP_COL_S_OP 8'h21
// ==========================================
// opcodes with a 2-bit or 4-bit field in the low bits
`define FBC_LOAD_AND_MODIFY_OP 8'b0011_00??
`define FBC_FLAG_TRUE_TEST_OP 8'b0011_01??
`define FBC_FLAG_FALSE_TEST_OP 8'b0011_10??
`define FBC_FLAG_SET_OP 8'b0011_11??
`define FBC_FLAG_CLEAR_OP 8'b0100_00??
`define FBC_PORT_BIT_SET_OP 8'b0100_01??
`define FBC_PORT_BIT_CLEAR_OP 8'b0100_10??
`define FBC_PORT_BIT_TEST_OP 8'b0100_11??
`define FBC_LOAD_COL_OP 8'b0101_????
// ==========================================
// two-byte opcodes
`define FBC_TIMER_LOAD_OP 8'h60
`define FBC_DUAL_PORT_IMMEDIATE_OUT_OP 8'h61
`define FBC_LOAD_POINTER_OP 8'h62
`define FBC_JUMP_OP 8'b0111_0???
`define FBC_CALL_OP 8'b0111_1???
// ==========================================
// data memory layout: 6 rows of 16 columns
`define FBC_RAM_WORDS 96
`define FBC_RAM_ROWS 3'd6
`define FBC_FLAG_ADDR 7'h5f
`define FBC_REG_X 7'h59
`define FBC_REG_Y 7'h5a
`define FBC_REG_Z 7'h5b
`define FBC_REG_W 7'h5c
`define FBC_REG_R 7'h5d
`define FBC_REG_S 7'h5e
// ==========================================
// port codes held in the column bits
`define FBC_PORT_A 4'h0
`define FBC_PORT_B 4'h1
`define FBC_PORT_C 4'h2
`define FBC_PORT_D 4'h3
`define FBC_PORT_E 4'h4
`define FBC_PORT_F 4'h5
`define FBC_PORT_G 4'h6
`define FBC_PORT_H 4'h7
`define FBC_PORT_I 4'h8
// ==========================================
// control flow and timer
`define FBC_RESET_PC 11'h000
`define FBC_INT_VEC 11'h010
`define FBC_PRE_SEED 6'h3f
`define FBC_PRE_TICK 6'h20
`define FBC_TM_LAST 6'h3f
`endif

// >>> logic/fbc_pkg.sv
// shared types of the controller core
package fbc_pkg;
  // gray-coded sequencer: first byte, then immediate byte
  typedef enum logic [1:0] {
    fbc_exec = 2'b00,
    fbc_imm = 2'b01
  } fbc_state_type;
endpackage

// >>> testbench/fbc_ports_model.sv
// far-side devices wired to the parallel ports of the controller core
`timescale 1ns/1ps
module fbc_ports_model (
  input logic clk,
  input logic [3:0] ext_a,
  input logic [3:0] ext_b,
  input logic [3:0] port_c_out,
  input logic port_c_oe_n,
  input logic [3:0] port_d_out,
  input logic port_d_oe_n,
  output logic [3:0] port_a,
  output logic [3:0] port_b,
  output logic [3:0] port_c_in,
  output logic [3:0] port_d_in
);
  logic [3:0] c_last_q = 4'h0;
  logic [3:0] d_last_q = 4'h0;
  // remember the last driven level of each two-way port
  always_ff @(posedge clk) begin
    if (!port_c_oe_n) c_last_q <= port_c_out;
    if (!port_d_oe_n) d_last_q <= port_d_out;
  end
  // a released pin floats: show the inverse so a stale value cannot pass
  assign port_c_in = port_c_oe_n ? ~c_last_q : port_c_out;
  assign port_d_in = port_d_oe_n ? ~d_last_q : port_d_out;
  // input-only ports carry whatever the outside world presents
  assign port_a = ext_a;
  assign port_b = ext_b;
endmodule // fbc_ports_model

// >>> testbench/fbc_core_test.sv
// self-checking bench of the controller core
`timescale 1ns/1ps
module fbc_core_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic int_req = 1'b0;
  logic [3:0] ext_a = 4'h9;
  logic [3:0] ext_b = 4'h6;
  logic [7:0] rom [0:2047];
  logic [10:0] rom_addr;
  logic [3:0] pa, pb, pci, pdi, pco, pdo, pe, pf, pg, ph;
  logic [2:0] pi;
  logic coe_n, doe_n, tflag, aflag;
  int bad_count = 0;
  int tests_run = 0;
  // ==========================================
  // clock and instances
  always #2 clk = ~clk;
  fbc_core fbc_core_i (.clk(clk), .rst_n(rst_n), .rom_addr(rom_addr),
    .rom_data(rom[rom_addr]), .int_req(int_req), .port_a(pa),
    .port_b(pb), .port_c_in(pci), .port_c_out(pco), .port_c_oe_n(coe_n),
    .port_d_in(pdi), .port_d_out(pdo), .port_d_oe_n(doe_n), .port_e(pe),
    .port_f(pf), .port_g(pg), .port_h(ph), .port_i(pi),
    .timeout_flag(tflag), .interrupt_allow_flag(aflag));
  fbc_ports_model fbc_ports_model_i (.clk(clk), .ext_a(ext_a),
    .ext_b(ext_b), .port_c_out(pco), .port_c_oe_n(coe_n),
    .port_d_out(pdo), .port_d_oe_n(doe_n), .port_a(pa), .port_b(pb),
    .port_c_in(pci), .port_d_in(pdi));
  // ==========================================
  // shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // load a program, then reset; first edge after release runs byte 0
  task automatic start(input logic [7:0] p[$]);
    foreach (rom[i]) rom[i] = 8'h00;
    foreach (p[i]) rom[i] = p[i];
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
  endtask
  // one byte executes per edge, so byte counts give exact times
  task automatic run(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    start('{8'h13, 8'h14});
    chk({coe_n, doe_n, tflag, aflag}, 8'h0c);
    chk({pco, pe}, 8'h00);
    chk(rom_addr[7:0], 8'h00);
    run(1);
    chk({7'h00, aflag}, 8'h01);
    run(1);
    chk({7'h00, aflag}, 8'h00);
  endtask
  task automatic t_dual();
    start('{8'h61, 8'ha5});
    run(2);
    chk({pdo, pco}, 8'ha5);
    chk({coe_n, doe_n}, 8'h00);
  endtask
  task automatic t_rotate();
    // zero a nibble, fold carry into acc to clear it, then rotate 1 twice
    start('{8'h62, 8'h00, 8'h0c, 8'h0b, 8'h05, 8'h0c, 8'h51, 8'h17,
            8'h01, 8'h01, 8'h11});
    run(11);
    chk({4'h0, pe}, 8'h08);
  endtask
  task automatic t_incr();
    start('{8'h5f, 8'h17, 8'h0b, 8'h02, 8'h0c, 8'h11, 8'h02, 8'h0a,
            8'h11});
    run(6);
    chk({4'h0, pe}, 8'h0f);
    run(3);
    chk({4'h0, pe}, 8'h01);
  endtask
  task automatic t_port();
    start('{8'h57, 8'h17, 8'h0f, 8'h51, 8'h17, 8'h0f, 8'h50, 8'h10,
            8'h11});
    run(3);
    chk({4'h0, ph}, 8'h07);
    run(3);
    chk({ph, pe}, 8'h70);
    run(3);
    chk({4'h0, pe}, {4'h0, ext_a});
  endtask
  task automatic t_flag();
    start('{8'h5a, 8'h17, 8'h3d, 8'h35, 8'h0c, 8'h11, 8'h39, 8'h0c,
            8'h11});
    run(6);
    chk({4'h0, pe}, 8'h0a);
    run(3);
    chk({4'h0, pe}, 8'h00);
  endtask
  task automatic t_timer();
    // prescaler leaves its seed and ticks 6 clocks after the load, then
    // every 63: counter 3e steps to 3f at once and wraps 63 clocks later
    start('{8'h60, 8'h3e});
    run(70);
    chk({7'h00, tflag}, 8'h00);
    run(1);
    chk({7'h00, tflag}, 8'h01);
  endtask
  task automatic t_arith();
    // f+f with carry skips; fixes add 6 then 10; swap steps col f to 0
    start('{8'h5f, 8'h17, 8'h0b, 8'h04, 8'h0c, 8'h06, 8'h07, 8'h08,
            8'h0c, 8'h11, 8'h5f, 8'h0a, 8'h11});
    run(10);
    chk({4'h0, pe}, 8'h0f);
    run(3);
    chk({4'h0, pe}, 8'h0e);
  endtask
  task automatic t_int();
    // request is tested and cleared, then taken once allowed
    start('{8'h51, 8'h17, 8'h0e, 8'h0c, 8'h0e, 8'h11, 8'h13, 8'h00,
            8'h0c, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h5e, 8'h17, 8'h11, 8'h15});
    int_req = 1'b1;
    run(6);
    chk({4'h0, pe}, 8'h01);
    int_req = 1'b0;
    run(1);
    int_req = 1'b1;
    run(2);
    chk({aflag, rom_addr[6:0]}, 8'h10);
    run(3);
    chk({4'h0, pe}, 8'h0e);
    run(3);
    chk({4'h0, pe}, 8'h00);
    int_req = 1'b0;
  endtask
  task automatic t_regs();
    // column 3 parks in Z and swaps back; pointer still selects port D
    start('{8'h53, 8'h17, 8'h1e, 8'h0c, 8'h1c, 8'h11, 8'h0c, 8'h17,
            8'h0f});
    run(6);
    chk({4'h0, pe}, 8'h03);
    run(3);
    chk({doe_n, 3'h0, pdo}, 8'h03);
  endtask
  task automatic t_outs();
    // codes 5, 6 and 8 reach F, G and the 3-bit I; then clear G bit 2
    start('{8'h55, 8'h17, 8'h0f, 8'h56, 8'h17, 8'h0f, 8'h58, 8'h17,
            8'h06, 8'h0f, 8'h56, 8'h4a});
    run(10);
    chk({pf, pg}, 8'h56);
    chk({5'h00, pi}, 8'h06);
    run(2);
    chk({4'h0, pg}, 8'h02);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    t_reset();
    t_dual();
    t_rotate();
    t_incr();
    t_port();
    t_flag();
    t_timer();
    t_arith();
    t_int();
    t_regs();
    t_outs();
    complete_run();
  end
  initial begin
    #8000;
    bad_count++;
    complete_run();
  end
endmodule // fbc_core_test
